// ===== bench/cdc_config_tb.sv
/*
  self-checking bench of the chop and current-detect configuration block.
  assumes cdc_defs.svh, cdc_pkg and the design modules are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cdc_defs.svh"

module cdc_config_tb;
  localparam logic [23:0] HIT   = 24'hffff00;
  localparam logic [23:0] QUIET = 24'h0000ff;

  logic                   clk;
  logic                   arst_n;
  cdc_pkg::cdc_bus_s      bus;
  logic [15:0]            rdData;
  logic                   modTick;
  logic                   chopStart;
  logic                   convVld;
  logic [3:0][23:0]       convData;
  logic                   chopOn;
  logic                   measureGo;
  logic                   detectFlag;
  int                     badCount;
  int                     nChecks;
  int                     cnt;
  logic [3:0]             rAddr [5];
  logic [15:0]            rWr   [5];
  logic [15:0]            rExp  [5];

  cdc_config #(.NUM_CH(4)) i_dut (
    .clk           (clk),
    .arst_n        (arst_n),
    .bus           (bus),
    .rdData_ff     (rdData),
    .modTick       (modTick),
    .chopStart     (chopStart),
    .convVld       (convVld),
    .convData      (convData),
    .chopOn_ff     (chopOn),
    .measureGo_ff  (measureGo),
    .detectFlag_ff (detectFlag)
  );

  always #5 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    nChecks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      badCount++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr   <= a;
    bus.wrData <= d;
    bus.wrEn   <= 1'b1;
    @(posedge clk);
    bus.wrEn   <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [3:0] a, input logic [15:0] e, input string what);
    @(posedge clk);
    bus.addr <= a;
    bus.rdEn <= 1'b1;
    @(posedge clk);
    bus.rdEn <= 1'b0;
    #1;
    chk(what, e, rdData);
  endtask : rdChk

  // one conversion; returns once its crossing could have reached the flag
  task automatic conv(input logic [3:0] hitMask);
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      convData[i] <= hitMask[i] ? HIT : QUIET;
    end
    convVld <= 1'b1;
    @(posedge clk);
    convVld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : conv

  task automatic flagChk(input logic e);
    chk("detect flag", {15'h0, e}, {15'h0, detectFlag});
  endtask : flagChk

  // counts modulator ticks from the taken start pulse to the settle pulse
  task automatic chop(input int maxWait, output int n);
    @(posedge clk);
    chopStart <= 1'b1;
    @(posedge clk);
    chopStart <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (measureGo !== 1'b1 && n < maxWait);
  endtask : chop

  initial begin
    repeat (50000) @(posedge clk);
    badCount++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    bus = '0;
    modTick = 1'b1;
    chopStart = 1'b0;
    convVld = 1'b0;
    convData = '0;
    badCount = 0;
    nChecks = 0;
    rAddr = '{4'h6, 4'h7, 4'h8, 4'h3, 4'h6};
    rWr   = '{16'h15a4, 16'h8001, 16'habcd, 16'h1234, 16'h0600};
    rExp  = '{16'h15a4, 16'h8001, 16'hab00, 16'h0000, 16'h0600};
    repeat (10) @(posedge clk);
    chk("outputs in reset", 16'h0, {rdData[12:0], chopOn, measureGo, detectFlag});
    arst_n <= 1'b1;
    rdChk(4'h6, 16'h0600, "config reset");
    rdChk(4'h7, 16'h0000, "threshold high reset");
    rdChk(4'h8, 16'h0000, "threshold low reset");
    for (int i = 0; i < 5; i++) begin
      wr(rAddr[i], rWr[i]);
      rdChk(rAddr[i], rExp[i], "register row");
      if (rAddr[i] == 4'h6) begin
        chk("chop enable", {15'h0, rWr[i][8]}, {15'h0, chopOn});
      end
    end
    // start pulse is ignored while chopping is off
    wr(4'h6, 16'h0000);
    chop(40, cnt);
    chk("settle while off", 16'd40, 16'(cnt));
    for (int code = 0; code < 14; code++) begin
      wr(4'h6, 16'(code << 9) | 16'h0100);
      chop(70000, cnt);
      chk("settle ticks", 16'(2 << code), 16'(cnt));
      @(posedge clk);
      #1;
      chk("settle pulse width", 16'h0, {15'h0, measureGo});
    end
    // longest code must still be settling long after the start pulse
    wr(4'h6, 16'h1f00);
    chop(100, cnt);
    chk("long settle running", 16'd100, 16'(cnt));
    rdChk(4'hf, 16'h0002, "settle status");
    wr(4'h6, 16'h0000);
    rdChk(4'hf, 16'h0000, "settle aborted");
    // threshold 0x000100, two crossings, 128-conversion window, any channel
    wr(4'h7, 16'h0001);
    wr(4'h8, 16'h0000);
    wr(4'h6, 16'h0011);
    repeat (2) @(posedge clk);
    conv(4'b0001);
    flagChk(1'b0);
    repeat (127) conv(4'b0000);
    conv(4'b0010);
    flagChk(1'b0);
    conv(4'b0100);
    flagChk(1'b1);
    rdChk(4'hf, 16'h0001, "status flag");
    wr(4'hf, 16'h0001);
    rdChk(4'hf, 16'h0000, "status cleared");
    // all channels, one crossing; mode off first so old counts are dropped
    wr(4'h6, 16'h0080);
    wr(4'h6, 16'h0081);
    repeat (2) @(posedge clk);
    conv(4'b0111);
    flagChk(1'b0);
    conv(4'b1111);
    flagChk(1'b1);
    // mode off: no detection
    wr(4'h6, 16'h0000);
    wr(4'hf, 16'h0001);
    conv(4'b1111);
    flagChk(1'b0);
    // low byte raises threshold to 0x000101, above the sample magnitude
    wr(4'h8, 16'h0100);
    wr(4'h6, 16'h0001);
    repeat (2) @(posedge clk);
    conv(4'b1111);
    flagChk(1'b0);
    // second reset mid-run
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rdChk(4'h6, 16'h0600, "config after reset");
    rdChk(4'h8, 16'h0000, "threshold low after reset");
    give_verdict();
  end
endmodule : cdc_config_tb

`default_nettype wire

// ===== src/cdc_config.sv
/*
  chop settle delay and current-detect configuration with its detector.
  assumes modTick, chopStart and conversion samples come from logic on clk.
*/
//
// Summary of operation
// - delay code 12:9 waits 2^(code+1) modulator periods; resets to 0011b.
// - bit 8 enables global chop; resets to zero.
// - bit 7 zero: any channel triggers; one: all channels must cross.
// - bits 6:4 set needed crossings as 2^code, 1 to 128; reset 0.
// - bits 3:1 pick window 128,256,512,768,1280,1792,2560,3584 conversions.
// - bit 0 enables current-detect mode; resets to zero.
// - sixteen-bit register holds upper threshold bits, resets to zero.
// - bits 15:8 of next register give low threshold byte of 24 bits.
`timescale 1ns/10ps
`default_nettype none
`include "cdc_defs.svh"

module cdc_config #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 arst_n,
  // register port
  input  wire cdc_pkg::cdc_bus_s                    bus,
  output logic [`CDC_DATA_W-1:0]                    rdData_ff,
  // modulator timing
  input  wire logic                                 modTick,
  input  wire logic                                 chopStart,
  // conversion results
  input  wire logic                                 convVld,
  input  wire logic [NUM_CH-1:0][`CDC_SAMPLE_W-1:0] convData,
  // control outputs
  output logic                                      chopOn_ff,
  output logic                                      measureGo_ff,
  output logic                                      detectFlag_ff
);

  cdc_pkg::cdc_cfg_s          cfg_ff;
  logic [`CDC_DATA_W-1:0]     thrHi_ff;
  logic [7:0]                 thrLo_ff;
  logic [`CDC_SAMPLE_W-1:0]   threshold;
  cdc_pkg::cdc_chop_e         chopState_ff;
  logic [`CDC_DLY_CNT_W-1:0]  dlyCnt_ff;
  logic [`CDC_DLY_CNT_W-1:0]  dlyTarget;
  logic [`CDC_WIN_CNT_W-1:0]  winCnt_ff;
  logic [`CDC_WIN_CNT_W-1:0]  winLen;
  logic [`CDC_HIT_CNT_W-1:0]  hitCnt_ff;
  logic [`CDC_HIT_CNT_W-1:0]  hitNeed;
  logic [`CDC_HIT_CNT_W-1:0]  nxt_hitCnt;
  logic [NUM_CH-1:0]          chExceed;
  logic [NUM_CH-1:0]          chVld;
  logic                       hit;
  logic                       detEnDly_ff;
  logic                       wrCfg;
  logic                       wrStat;

  assign wrCfg  = bus.wrEn && (bus.addr == `CDC_ADDR_CFG);
  assign wrStat = bus.wrEn && (bus.addr == `CDC_ADDR_STAT);

  // configuration and threshold registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff   <= `CDC_CFG_RST;
      thrHi_ff <= `CDC_THR_HI_RST;
      thrLo_ff <= `CDC_THR_LO_RST;
    end else if (bus.wrEn) begin
      unique case (bus.addr)
        `CDC_ADDR_CFG:    cfg_ff   <= bus.wrData;
        `CDC_ADDR_THR_HI: thrHi_ff <= bus.wrData;
        `CDC_ADDR_THR_LO: thrLo_ff <= bus.wrData[15:`CDC_POS_THR_LO];
        default: ;
      endcase
    end
  end

  assign threshold = {thrHi_ff, thrLo_ff};

  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= '0;
    end else if (bus.rdEn) begin
      unique case (bus.addr)
        `CDC_ADDR_CFG:    rdData_ff <= cfg_ff;
        `CDC_ADDR_THR_HI: rdData_ff <= thrHi_ff;
        `CDC_ADDR_THR_LO: rdData_ff <= {thrLo_ff, 8'h00};
        `CDC_ADDR_STAT:   rdData_ff <= {14'h0000, chopState_ff == cdc_pkg::CDC_SETTLE,
                                        detectFlag_ff};
        default:          rdData_ff <= '0;
      endcase
    end else begin
      rdData_ff <= '0;
    end
  end

  // chop enable output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chopOn_ff <= 1'b0;
    end else begin
      chopOn_ff <= cfg_ff.global_chop_on;
    end
  end

  // chop settle delay
  assign dlyTarget = `CDC_DLY_CNT_W'(1) << ({1'b0, cfg_ff.chop_settle_delay} + 5'h01);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chopState_ff <= cdc_pkg::CDC_IDLE;
      dlyCnt_ff    <= '0;
      measureGo_ff <= 1'b0;
    end else begin
      measureGo_ff <= 1'b0;
      if (!cfg_ff.global_chop_on) begin
        chopState_ff <= cdc_pkg::CDC_IDLE;
        dlyCnt_ff    <= '0;
      end else if (chopStart) begin
        chopState_ff <= cdc_pkg::CDC_SETTLE;
        dlyCnt_ff    <= '0;
      end else begin
        unique case (chopState_ff)
          cdc_pkg::CDC_IDLE: ;
          cdc_pkg::CDC_SETTLE: begin
            if (modTick) begin
              if (dlyCnt_ff == dlyTarget - `CDC_DLY_CNT_W'(1)) begin
                measureGo_ff <= 1'b1;
                chopState_ff <= cdc_pkg::CDC_IDLE;
                dlyCnt_ff    <= '0;
              end else begin
                dlyCnt_ff <= dlyCnt_ff + `CDC_DLY_CNT_W'(1);
              end
            end
          end
          default: begin
            chopState_ff <= cdc_pkg::CDC_IDLE;
            dlyCnt_ff    <= '0;
          end
        endcase
      end
    end
  end

  // per-channel magnitude compare
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : gCh
      cdc_mag_cmp uCmp (
        .clk       (clk),
        .arst_n    (arst_n),
        .sampleVld (convVld),
        .sample    (convData[ch]),
        .threshold (threshold),
        .exceed_ff (chExceed[ch]),
        .vld_ff    (chVld[ch])
      );
    end
  endgenerate

  assign hit = cfg_ff.detect_all_channels ? (&chExceed) : (|chExceed);

  // measurement length lookup
  always_comb begin
    unique case (cfg_ff.detect_measure_length)
      3'h0: winLen = 12'd128;
      3'h1: winLen = 12'd256;
      3'h2: winLen = 12'd512;
      3'h3: winLen = 12'd768;
      3'h4: winLen = 12'd1280;
      3'h5: winLen = 12'd1792;
      3'h6: winLen = 12'd2560;
      3'h7: winLen = 12'd3584;
    endcase
  end

  assign hitNeed    = `CDC_HIT_CNT_W'(1) << cfg_ff.detect_crossing_count;
  assign nxt_hitCnt = (hit && hitCnt_ff != '1) ? hitCnt_ff + `CDC_HIT_CNT_W'(1) : hitCnt_ff;

  // detection window and crossing counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detEnDly_ff <= 1'b0;
      winCnt_ff   <= '0;
      hitCnt_ff   <= '0;
    end else begin
      detEnDly_ff <= cfg_ff.detect_mode_on;
      if (!cfg_ff.detect_mode_on || !detEnDly_ff) begin
        winCnt_ff <= '0;
        hitCnt_ff <= '0;
      end else if (chVld[0]) begin
        if (winCnt_ff == winLen - `CDC_WIN_CNT_W'(1)) begin
          winCnt_ff <= '0;
          hitCnt_ff <= '0;
        end else begin
          winCnt_ff <= winCnt_ff + `CDC_WIN_CNT_W'(1);
          hitCnt_ff <= nxt_hitCnt;
        end
      end
    end
  end

  // sticky detection flag, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detectFlag_ff <= 1'b0;
    end else if (cfg_ff.detect_mode_on && detEnDly_ff && chVld[0] && nxt_hitCnt >= hitNeed) begin
      detectFlag_ff <= 1'b1;
    end else if (wrStat && bus.wrData[`CDC_STAT_FLAG]) begin
      detectFlag_ff <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_settle_last;
    chopState_ff == cdc_pkg::CDC_SETTLE && modTick && !chopStart && cfg_ff.global_chop_on
      && dlyCnt_ff == dlyTarget - `CDC_DLY_CNT_W'(1);
  endsequence

  sequence s_go_pulse;
    measureGo_ff ##1 !measureGo_ff;
  endsequence

  a_chop_delay_end: assert property (s_settle_last |=> s_go_pulse)
    else $error("settle delay end did not give one start pulse");
  a_chop_delay_target: assert property (cfg_ff.chop_settle_delay == 4'h3 |->
      dlyTarget == `CDC_DLY_CNT_W'(16))
    else $error("delay code three is not sixteen periods");
  a_chop_delay_max: assert property (cfg_ff.chop_settle_delay == 4'hf |->
      dlyTarget == 17'h10000)
    else $error("delay code fifteen is not the longest wait");
  a_chop_enable_out: assert property (wrCfg ##1 1'b1 |=>
      chopOn_ff == $past(bus.wrData[`CDC_POS_CHOP], 2))
    else $error("chop enable output does not follow write");
  a_scope_any_all: assert property (chVld[0] && (chExceed != '0) && (chExceed != '1) |->
      hit == !cfg_ff.detect_all_channels)
    else $error("channel scope selection wrong");
  a_crossing_need: assert property (hitNeed[cfg_ff.detect_crossing_count]
      && $onehot(hitNeed))
    else $error("required crossing count wrong");
  a_length_lut: assert property (cfg_ff.detect_measure_length == 3'h7 |->
      winLen == 12'd3584)
    else $error("longest measurement length wrong");
  a_detect_off_idle: assert property (!cfg_ff.detect_mode_on |=>
      winCnt_ff == '0 && hitCnt_ff == '0)
    else $error("detector counts while disabled");
  a_thr_high_wr: assert property (bus.wrEn && bus.addr == `CDC_ADDR_THR_HI |=>
      threshold[23:8] == $past(bus.wrData))
    else $error("upper threshold write lost");
  a_thr_low_join: assert property (bus.wrEn && bus.addr == `CDC_ADDR_THR_LO |=>
      threshold[7:0] == $past(bus.wrData[15:8]))
    else $error("low threshold byte not joined");
  a_flag_set_wins: assert property (cfg_ff.detect_mode_on && detEnDly_ff && chVld[0]
      && nxt_hitCnt >= hitNeed |=> detectFlag_ff)
    else $error("detection flag not raised at required count");

endmodule : cdc_config
`default_nettype wire

// ===== src/cdc_defs.svh
/*
  register offsets, field positions, reset values and widths of the
  chop and current-detect configuration block.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef CDC_DEFS_SVH
`define CDC_DEFS_SVH

`define CDC_ADDR_W        4
`define CDC_DATA_W        16
`define CDC_ADDR_CFG      4'h6
`define CDC_ADDR_THR_HI   4'h7
`define CDC_ADDR_THR_LO   4'h8
`define CDC_ADDR_STAT     4'hf

`define CDC_CFG_RST       16'h0600
`define CDC_THR_HI_RST    16'h0000
`define CDC_THR_LO_RST    8'h00

`define CDC_POS_RSVD      13
`define CDC_POS_DLY       9
`define CDC_POS_CHOP      8
`define CDC_POS_ALLCH     7
`define CDC_POS_NUM       4
`define CDC_POS_LEN       1
`define CDC_POS_DETEN     0
`define CDC_POS_THR_LO    8

`define CDC_STAT_FLAG     0
`define CDC_STAT_SETTLE   1

`define CDC_SAMPLE_W      24
`define CDC_DLY_CNT_W     17
`define CDC_WIN_CNT_W     12
`define CDC_HIT_CNT_W     8

`endif

// ===== src/cdc_mag_cmp.sv
/*
  one channel: magnitude of a signed sample against the detection threshold.
  assumes sample and valid come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cdc_defs.svh"

module cdc_mag_cmp (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // sample in
  input  wire logic                      sampleVld,
  input  wire logic [`CDC_SAMPLE_W-1:0]  sample,
  input  wire logic [`CDC_SAMPLE_W-1:0]  threshold,
  // result
  output logic                           exceed_ff,
  output logic                           vld_ff
);

  logic [`CDC_SAMPLE_W-1:0] magnitude;

  assign magnitude = sample[`CDC_SAMPLE_W-1] ? (~sample + `CDC_SAMPLE_W'(1)) : sample;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exceed_ff <= 1'b0;
      vld_ff    <= 1'b0;
    end else begin
      vld_ff <= sampleVld;
      if (sampleVld) begin
        exceed_ff <= (magnitude >= threshold);
      end
    end
  end

endmodule : cdc_mag_cmp
`default_nettype wire

// ===== src/cdc_pkg.sv
/*
  types of the chop and current-detect configuration block.
  assumes cdc_defs.svh is on the include path.
*/
`include "cdc_defs.svh"

package cdc_pkg;

  typedef struct packed {
    logic [2:0] reserved;
    logic [3:0] chop_settle_delay;
    logic       global_chop_on;
    logic       detect_all_channels;
    logic [2:0] detect_crossing_count;
    logic [2:0] detect_measure_length;
    logic       detect_mode_on;
  } cdc_cfg_s;

  typedef struct packed {
    logic [`CDC_ADDR_W-1:0] addr;
    logic [`CDC_DATA_W-1:0] wrData;
    logic                   wrEn;
    logic                   rdEn;
  } cdc_bus_s;

  typedef enum logic [1:0] {
    CDC_IDLE   = 2'b01,
    CDC_SETTLE = 2'b10
  } cdc_chop_e;

endpackage : cdc_pkg
